/* core/ptb_pkg.sv */
package ptb_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] PTB_CTRL_OFS = 8'h00;
  localparam logic [7:0] PTB_STAT_OFS = 8'h04;
  localparam logic [7:0] PTB_CNT_OFS = 8'h08;

  // ==========================================================
  // Control field positions
  localparam int PTB_SRC_BIT = 0;
  localparam int PTB_DIV_LSB = 1;
  localparam int PTB_RLOW_BIT = 5;
  localparam int PTB_RHIGH_BIT = 6;
  localparam int PTB_BYP_BIT = 7;
  localparam int PTB_HOLDN_BIT = 8;
  localparam logic [8:0] PTB_CTRL_RST = 9'h100;

  // ==========================================================
  // Special division codes
  localparam logic [3:0] PTB_CODE_PASS = 4'h0;
  localparam logic [3:0] PTB_CODE_LOW_A = 4'hc;
  localparam logic [3:0] PTB_CODE_LOW_B = 4'hd;
  localparam logic [3:0] PTB_CODE_EXT = 4'hf;

  // ==========================================================
  // First stage and timing
  localparam logic [3:0] PTB_DEC_MAX = 4'h9;
  localparam logic [31:0] PTB_DEC_RATIO = 32'd10;
  localparam int PTB_CLK_NS = 100;
  localparam int PTB_RESET_MIN_NS = 10000;
  localparam int PTB_RESET_MIN_CYC =
    (PTB_RESET_MIN_NS + PTB_CLK_NS - 1) / PTB_CLK_NS;
  localparam int PTB_CLK_KHZ = 1000000 / PTB_CLK_NS;
  localparam int PTB_OSC_KHZ = 1000;
  localparam int PTB_OSC_HALF_CYC = PTB_CLK_KHZ / (2 * PTB_OSC_KHZ);

  // Control register as one carrier
  typedef struct packed {
    logic hold_n;
    logic bypass;
    logic reset_high;
    logic reset_low;
    logic [3:0] div_sel;
    logic source_select;
  } ptb_ctrl_s;

endpackage

/* core/ptb_time_base.sv */
`timescale 1ns/1ps
module ptb_time_base
  import ptb_pkg::*;
#(
  parameter logic [15:0][31:0] DIV_TABLE = {
    32'd1, 32'd1, 32'd1, 32'd1, 32'd3600000000, 32'd600000000,
    32'd60000000, 32'd100000000, 32'd10000000, 32'd1000000,
    32'd100000, 32'd10000, 32'd1000, 32'd100, 32'd10, 32'd1},
  parameter int OSC_HALF = PTB_OSC_HALF_CYC
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Pins
  input wire logic external_clock_input,
  output logic time_base_out,
  output logic oscillator_monitor
);

  // ==========================================================
  // Bus slave: zero wait states, always OKAY
  ptb_ctrl_s ctl_ff, nxt_ctl;
  logic wr_pend_ff, nxt_wr_pend;
  logic [7:0] wr_addr_ff, nxt_wr_addr;
  logic [31:0] rdata_ff, nxt_rdata;
  logic addr_ok;
  logic [3:0] dec_ff, nxt_dec;
  logic [31:0] up_ff, nxt_up;
  logic osc_ff, nxt_osc;
  logic tb_ff, nxt_tb;

  assign addr_ok = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_ff;

  // Address phase capture, write in data phase, read data registered
  always_comb begin
    nxt_wr_pend = addr_ok && hwrite;
    nxt_wr_addr = wr_addr_ff;
    nxt_rdata = rdata_ff;
    nxt_ctl = ctl_ff;
    if (addr_ok) begin
      nxt_wr_addr = haddr[7:0];
      unique case ({haddr[31:8], haddr[7:0]} == {24'h0, PTB_CTRL_OFS} ?
                   2'd0 : haddr[31:0] == {24'h0, PTB_STAT_OFS} ? 2'd1 :
                   haddr[31:0] == {24'h0, PTB_CNT_OFS} ? 2'd2 : 2'd3)
        2'd0: nxt_rdata = {23'h0, ctl_ff};
        2'd1: nxt_rdata = {26'h0, dec_ff, osc_ff, tb_ff};
        2'd2: nxt_rdata = up_ff;
        default: nxt_rdata = 32'h0;
      endcase
    end
    if (wr_pend_ff && wr_addr_ff == PTB_CTRL_OFS) begin
      nxt_ctl = ptb_ctrl_s'(hwdata[8:0]);
    end
  end

  // Bus registers; hsize ignored, only whole words are used
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      rdata_ff <= 32'h0;
      ctl_ff <= ptb_ctrl_s'(PTB_CTRL_RST);
    end else begin
      wr_pend_ff <= nxt_wr_pend;
      wr_addr_ff <= nxt_wr_addr;
      rdata_ff <= nxt_rdata;
      ctl_ff <= nxt_ctl;
    end
  end

  // ==========================================================
  // Reset pulse stretchers: a short software pulse still lasts 10 us
  logic [1:0] rq_prev_ff, nxt_rq_prev;
  logic [1:0][7:0] str_ff, nxt_str;
  logic [1:0] rq_lvl;
  logic rst_low, rst_high;

  assign rq_lvl = {ctl_ff.reset_high, ctl_ff.reset_low};

  always_comb begin
    nxt_rq_prev = rq_lvl;
    for (int i = 0; i < 2; i++) begin
      if (rq_lvl[i] && !rq_prev_ff[i]) begin
        nxt_str[i] = 8'(PTB_RESET_MIN_CYC - 1);
      end else if (str_ff[i] != 8'h00) begin
        nxt_str[i] = str_ff[i] - 8'h01;
      end else begin
        nxt_str[i] = 8'h00;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rq_prev_ff <= 2'b00;
      str_ff <= '0;
    end else begin
      rq_prev_ff <= nxt_rq_prev;
      str_ff <= nxt_str;
    end
  end

  // Level while held, plus the stretch; low wins over high
  assign rst_low = rq_lvl[0] || str_ff[0] != 8'h00;
  assign rst_high = !rst_low && (rq_lvl[1] || str_ff[1] != 8'h00);

  // ==========================================================
  // Internal oscillator model, parked low while held
  logic [15:0] ph_ff, nxt_ph;

  always_comb begin
    nxt_ph = ph_ff;
    nxt_osc = osc_ff;
    if (!ctl_ff.hold_n) begin
      nxt_ph = 16'h0;
      nxt_osc = 1'b0;
    end else if (ph_ff == 16'(OSC_HALF - 1)) begin
      nxt_ph = 16'h0;
      nxt_osc = !osc_ff;
    end else begin
      nxt_ph = ph_ff + 16'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_ff <= 16'h0;
      osc_ff <= 1'b0;
    end else begin
      ph_ff <= nxt_ph;
      osc_ff <= nxt_osc;
    end
  end

  assign oscillator_monitor = osc_ff;

  // ==========================================================
  // Source mux and falling-edge tick
  logic src_lvl, src_prev_ff, tick;

  assign src_lvl = ctl_ff.source_select ? external_clock_input : osc_ff;
  assign tick = src_prev_ff && !src_lvl;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_prev_ff <= 1'b0;
    end else begin
      src_prev_ff <= src_lvl;
    end
  end

  // ==========================================================
  // Per-code limits for the upper stage
  logic [15:0][31:0] lim_dec;
  logic [15:0] dec_ok;

  for (genvar g = 0; g < 16; g++) begin : g_lim
    assign dec_ok[g] = DIV_TABLE[g] >= PTB_DEC_RATIO;
    assign lim_dec[g] = dec_ok[g] ? DIV_TABLE[g] / PTB_DEC_RATIO
                                  : DIV_TABLE[g];
  end

  logic use_dec;
  logic [31:0] lim;

  // Bypass drops the decade stage, so the ratio shrinks tenfold
  assign use_dec = dec_ok[ctl_ff.div_sel] && !ctl_ff.bypass;
  assign lim = dec_ok[ctl_ff.div_sel] ? lim_dec[ctl_ff.div_sel]
                                      : DIV_TABLE[ctl_ff.div_sel];

  // ==========================================================
  // Divider chain: decade stage gates the synchronous upper stage
  always_comb begin
    nxt_dec = dec_ff;
    nxt_up = up_ff;
    if (rst_low) begin
      nxt_dec = 4'h0;
      nxt_up = 32'h0;
    end else if (rst_high) begin
      nxt_dec = use_dec ? PTB_DEC_MAX : 4'h0;
      nxt_up = lim - 32'h1;
    end else if (tick) begin
      if (use_dec && dec_ff != PTB_DEC_MAX) begin
        nxt_dec = dec_ff + 4'h1;
      end else begin
        nxt_dec = 4'h0;
        nxt_up = (up_ff >= lim - 32'h1) ? 32'h0 : up_ff + 32'h1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dec_ff <= 4'h0;
      up_ff <= 32'h0;
    end else begin
      dec_ff <= nxt_dec;
      up_ff <= nxt_up;
    end
  end

  // ==========================================================
  // Output: high in the upper half, so the wrap is the falling edge
  logic div_lvl;

  always_comb begin
    if (lim <= 32'h1) begin
      div_lvl = use_dec ? dec_ff >= 4'h5 : src_lvl;
    end else begin
      div_lvl = up_ff >= (lim >> 1);
    end
    unique case (ctl_ff.div_sel)
      PTB_CODE_PASS: nxt_tb = src_lvl;
      PTB_CODE_LOW_A, PTB_CODE_LOW_B: nxt_tb = 1'b0;
      PTB_CODE_EXT: nxt_tb = external_clock_input;
      default: nxt_tb = div_lvl;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tb_ff <= 1'b0;
    end else begin
      tb_ff <= nxt_tb;
    end
  end

  // Consumers use the falling edge; rising edge may shift on code change
  assign time_base_out = tb_ff;

  // ==========================================================
  // Checks
  logic quiet;
  assign quiet = !rst_low && !rst_high;

  chk_ext_advance: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (ctl_ff.source_select && src_prev_ff && !external_clock_input
     && quiet && use_dec) |=> (dec_ff != $past(dec_ff)))
    else $error("external falling edge did not advance");

  chk_osc_source: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (!ctl_ff.source_select && $stable(ctl_ff.source_select)
     && $fell(osc_ff) && quiet && use_dec)
    |=> (dec_ff != $past(dec_ff)))
    else $error("oscillator falling edge did not advance");

  chk_reset_low: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rst_low |=> (dec_ff == 4'h0 && up_ff == 32'h0))
    else $error("counters not cleared by reset-to-lowest");

  chk_reset_high: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (rst_high && $stable(ctl_ff)) |=> (up_ff == $past(lim) - 32'h1))
    else $error("counters not loaded by reset-to-highest");

  chk_max_falls: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (quiet && tick && lim > 32'h1 && up_ff == lim - 32'h1
     && (!use_dec || dec_ff == PTB_DEC_MAX) && $stable(ctl_ff)
     && ctl_ff.div_sel != PTB_CODE_PASS && ctl_ff.div_sel != PTB_CODE_EXT)
    |=> ##1 !time_base_out)
    else $error("no falling output after maximum state");

  chk_pass_zero: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (ctl_ff.div_sel == PTB_CODE_PASS) |=> (time_base_out == $past(src_lvl)))
    else $error("code zero did not pass source");

  chk_force_low: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (ctl_ff.div_sel == PTB_CODE_LOW_A || ctl_ff.div_sel == PTB_CODE_LOW_B)
    |=> !time_base_out)
    else $error("output not forced low");

  chk_ext_pass: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (ctl_ff.div_sel == PTB_CODE_EXT)
    |=> (time_base_out == $past(external_clock_input)))
    else $error("external input not passed");

  chk_hold_park: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !ctl_ff.hold_n |=> (!oscillator_monitor && ph_ff == 16'h0))
    else $error("oscillator not parked while held");

  chk_upper_sync: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (quiet && use_dec && dec_ff != PTB_DEC_MAX) |=> $stable(up_ff))
    else $error("upper stage moved without decade carry");

endmodule // ptb_time_base

/* sim/ptb_ext_src.sv */
`timescale 1ns/1ps
// ==========================================================
// External clock source driving the divider's input pin
module ptb_ext_src (
  // Clock
  input wire logic hclk,
  // Control from bench
  input wire logic run,
  input wire logic [3:0] half,
  // Pin
  output logic ext_clk
);
  logic [3:0] cnt;
  // Idles high so a stop never leaves a stray falling edge
  initial begin
    ext_clk = 1'b1;
    cnt = 4'h0;
  end
  // Finishes a low half before parking, keeping each half whole
  always @(posedge hclk) begin
    if (run || !ext_clk) begin
      if (cnt >= half - 4'h1) begin
        ext_clk <= !ext_clk;
        cnt <= 4'h0;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end else begin
      cnt <= 4'h0;
    end
  end
endmodule // ptb_ext_src

/* sim/programmable_time_base_divider_tb.sv */
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the time-base divider
module programmable_time_base_divider_tb;
  import ptb_pkg::*;
  localparam int OSCH = 2;
  localparam int RW = PTB_RESET_MIN_CYC + 10;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, ext, tbo, osc;
  logic run = 1'b0;
  logic src = 1'b0;
  logic [31:0] hrdata, rd;
  logic ext_q = 1'b1, osc_q = 1'b0, sel_q = 1'b1, tbo_q = 1'b0;
  int failures = 0, n_checks = 0, cyc = 0, ticks = 0, seed = 88070, n;
  int falls[$];

  // Clock at 10 MHz
  always #50 hclk = ~hclk;

  ptb_time_base #(.OSC_HALF(OSCH)) uut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .external_clock_input(ext), .time_base_out(tbo),
    .oscillator_monitor(osc));
  ptb_ext_src ext_src (.hclk(hclk), .run(run), .half(4'h2), .ext_clk(ext));

  // ==========================================================
  // Reference model: source ticks and output fall stamps
  always @(posedge hclk) begin
    ext_q <= ext;
    osc_q <= osc;
    sel_q <= src ? ext : osc;
    tbo_q <= tbo;
    cyc <= cyc + 1;
    if (sel_q && !(src ? ext : osc)) ticks <= ticks + 1;
    if (tbo_q && !tbo) falls.push_back(ticks);
    if (cyc == 40000) begin
      failures++;
      stop_test();
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    if (failures == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // One single transfer; read data taken at the data phase's end
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    check("hresp", hresp, 32'h0);
  endtask

  // Control write with random filler in the unused upper bits
  task automatic wctl(input logic [8:0] v);
    logic [31:0] r;
    r = $random(seed);
    bus(1'b1, PTB_CTRL_OFS, {r[31:9], v});
  endtask

  function automatic logic [8:0] mk(input logic s, input logic [3:0] c,
                                    input logic rl, rh, by, hn);
    return {hn, by, rh, rl, c, s};
  endfunction

  // Output against a reference: 0 external, 1 oscillator, 2 low
  task automatic follow(input logic [8:0] v, input int kind);
    wctl(v);
    src <= v[0];
    repeat (2) @(posedge hclk);
    repeat (40) begin
      @(posedge hclk);
      #1;
      check("follow", tbo, kind == 0 ? ext_q : kind == 1 ? osc_q : 1'b0);
    end
    @(posedge hclk);
  endtask

  // Output period in source ticks; first period skipped as settling
  task automatic period(input logic [8:0] v, input int d);
    wctl(v);
    src <= v[0];
    falls.delete();
    run <= 1'b1;
    n = 0;
    while (falls.size() < 3 && n < 5000) begin
      @(posedge hclk);
      n++;
    end
    check("fall_count", falls.size() >= 3, 1'b1);
    if (falls.size() >= 3) check("period", falls[2] - falls[1], d);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] v;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, PTB_CTRL_OFS, 32'h0);
    check("ctrl_reset", rd, {23'h0, PTB_CTRL_RST});
    bus(1'b0, 8'h0c, 32'h0);
    check("unmapped", rd, 32'h0);
    repeat (3) begin
      v = $random(seed);
      wctl(v[8:0]);
      bus(1'b0, PTB_CTRL_OFS, 32'h0);
      check("ctrl_rw", rd, {23'h0, v[8:0]});
    end
    // Source running while held at lowest: counters must stay zero
    run <= 1'b1;
    src <= 1'b1;
    wctl(mk(1'b1, 4'h2, 1'b1, 1'b0, 1'b0, 1'b1));
    repeat (RW) @(posedge hclk);
    bus(1'b0, PTB_STAT_OFS, 32'h0);
    check("stat_low", rd & 32'h3d, 32'h0);
    bus(1'b0, PTB_CNT_OFS, 32'h0);
    check("count_low", rd, 32'h0);
    period(mk(1'b1, 4'h1, 1'b0, 1'b0, 1'b0, 1'b1), 10);
    period(mk(1'b1, 4'h2, 1'b0, 1'b0, 1'b0, 1'b1), 100);
    period(mk(1'b1, 4'h2, 1'b0, 1'b0, 1'b1, 1'b1), 10);
    period(mk(1'b0, 4'h1, 1'b0, 1'b0, 1'b0, 1'b1), 10);
    follow(mk(1'b1, 4'h0, 1'b0, 1'b0, 1'b0, 1'b1), 0);
    follow(mk(1'b0, 4'h0, 1'b0, 1'b0, 1'b0, 1'b1), 1);
    follow(mk(1'b0, PTB_CODE_EXT, 1'b0, 1'b0, 1'b0, 1'b1), 0);
    follow(mk(1'b1, PTB_CODE_LOW_A, 1'b0, 1'b0, 1'b0, 1'b1), 2);
    follow(mk(1'b0, PTB_CODE_LOW_B, 1'b0, 1'b0, 1'b0, 1'b1), 2);
    // Highest state with ticks arriving meanwhile, then one tick
    src <= 1'b1;
    wctl(mk(1'b1, 4'h2, 1'b0, 1'b1, 1'b0, 1'b1));
    repeat (RW) @(posedge hclk);
    run <= 1'b0;
    repeat (6) @(posedge hclk);
    wctl(mk(1'b1, 4'h2, 1'b0, 1'b0, 1'b0, 1'b1));
    repeat (RW) @(posedge hclk);
    #1;
    check("high_held", tbo, 1'b1);
    run <= 1'b1;
    do begin
      @(posedge hclk);
      #1;
    end while (ext_q !== 1'b0);
    run <= 1'b0;
    n = 0;
    while (tbo === 1'b1 && n < 8) begin
      @(posedge hclk);
      #1;
      n++;
    end
    check("high_fall", n <= 4 && tbo === 1'b0, 1'b1);
    // Oscillator parked, then a whole first half after release
    @(posedge hclk);
    wctl(mk(1'b0, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0));
    repeat (2 * OSCH) @(posedge hclk);
    #1;
    check("osc_parked", osc, 1'b0);
    @(posedge hclk);
    wctl(mk(1'b0, 4'h0, 1'b0, 1'b0, 1'b0, 1'b1));
    n = 0;
    while (osc === 1'b0 && n < 20) begin
      @(posedge hclk);
      #1;
      n++;
    end
    check("osc_first", n >= OSCH && n <= OSCH + 2, 1'b1);
    n = 0;
    while (osc === 1'b1 && n < 20) begin
      @(posedge hclk);
      #1;
      n++;
    end
    check("osc_high", n, OSCH);
    stop_test();
  end
endmodule // programmable_time_base_divider_tb
